// ==== brc_router.sv ====
// Top of the response and cache-attribute router, a single-target forwarding stage.
// Assumes masters keep the allocate hints legal and the downstream slave follows the bus protocol.
// Notes on behaviour
// - Responses: zero okay, one exclusive okay, two slave error, three decode error.
// - A write burst gets exactly one response, not one per beat.
// - Okay answers normal success, failed exclusive, and unsupported exclusive.
// - Exclusive okay only when the exclusive access really succeeded.
// - Slave error only for real faults like overrun, bad size, timeout.
// - An address that maps nowhere is answered with decode error.
// - Undecodable accesses go to an internal default target giving decode error.
// - A decode error answer still carries out every data beat first.
// - A memory slave handles every transaction type correctly.
// - A peripheral slave still completes odd accesses within protocol.
// - Bufferable bit lets components delay arrival by any number of cycles.
// - Bit one clear forbids allocation; set allows merge, prefetch, reuse.
// - Bit one high marks modifiable, low marks non-modifiable.
// - Non-modifiable transactions are never split or merged unless allowed.
// - Non-modifiable: address, region, size, length, type, lock, protection pass unchanged.
// - Non-modifiable: only clearing bufferable allowed; ID and QoS may change.
// - Non-modifiable bursts over sixteen beats may be split with adjusted address.
// - Non-modifiable exclusive may change size and length keeping byte total.
// - A narrowing converter must modify and may flag that it did.
`timescale 1ns/1ps
`default_nettype none
module brc_router
  import brc_pkg::*;
#(
  parameter int ADDR_W = 32,
  parameter int ID_W = 4,
  parameter int DATA_W = 32,
  parameter logic [31:0] MAP_BASE = 32'h0000_0000,
  parameter logic [31:0] MAP_SIZE = 32'h0001_0000
) (
  // Clock and reset.
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  // Configuration.
  input wire logic clear_buf_in,
  // Upstream write address.
  input wire logic s_awvalid_in,
  output logic s_awready_out,
  input wire logic [ADDR_W-1:0] s_awaddr_in,
  input wire logic [ID_W-1:0] s_awid_in,
  input wire logic [7:0] s_awlen_in,
  input wire logic [2:0] s_awsize_in,
  input wire logic [1:0] s_awburst_in,
  input wire logic s_awlock_in,
  input wire logic [2:0] s_awprot_in,
  input wire logic [3:0] s_awcache_in,
  input wire logic [3:0] s_awqos_in,
  input wire logic [3:0] s_awregion_in,
  // Upstream write data.
  input wire logic s_wvalid_in,
  output logic s_wready_out,
  input wire logic [DATA_W-1:0] s_wdata_in,
  input wire logic [DATA_W/8-1:0] s_wstrb_in,
  input wire logic s_wlast_in,
  // Upstream write response.
  output logic s_bvalid_out,
  input wire logic s_bready_in,
  output logic [ID_W-1:0] s_bid_out,
  output logic [1:0] s_bresp_out,
  // Upstream read address.
  input wire logic s_arvalid_in,
  output logic s_arready_out,
  input wire logic [ADDR_W-1:0] s_araddr_in,
  input wire logic [ID_W-1:0] s_arid_in,
  input wire logic [7:0] s_arlen_in,
  input wire logic [2:0] s_arsize_in,
  input wire logic [1:0] s_arburst_in,
  input wire logic s_arlock_in,
  input wire logic [2:0] s_arprot_in,
  input wire logic [3:0] s_arcache_in,
  input wire logic [3:0] s_arqos_in,
  input wire logic [3:0] s_arregion_in,
  // Upstream read data.
  output logic s_rvalid_out,
  input wire logic s_rready_in,
  output logic [ID_W-1:0] s_rid_out,
  output logic [DATA_W-1:0] s_rdata_out,
  output logic [1:0] s_rresp_out,
  output logic s_rlast_out,
  // Downstream write address.
  output logic m_awvalid_out,
  input wire logic m_awready_in,
  output logic [ADDR_W-1:0] m_awaddr_out,
  output logic [ID_W-1:0] m_awid_out,
  output logic [7:0] m_awlen_out,
  output logic [2:0] m_awsize_out,
  output logic [1:0] m_awburst_out,
  output logic m_awlock_out,
  output logic [2:0] m_awprot_out,
  output logic [3:0] m_awcache_out,
  output logic [3:0] m_awqos_out,
  output logic [3:0] m_awregion_out,
  // Downstream write data.
  output logic m_wvalid_out,
  input wire logic m_wready_in,
  output logic [DATA_W-1:0] m_wdata_out,
  output logic [DATA_W/8-1:0] m_wstrb_out,
  output logic m_wlast_out,
  // Downstream write response.
  input wire logic m_bvalid_in,
  output logic m_bready_out,
  input wire logic [ID_W-1:0] m_bid_in,
  input wire logic [1:0] m_bresp_in,
  // Downstream read address.
  output logic m_arvalid_out,
  input wire logic m_arready_in,
  output logic [ADDR_W-1:0] m_araddr_out,
  output logic [ID_W-1:0] m_arid_out,
  output logic [7:0] m_arlen_out,
  output logic [2:0] m_arsize_out,
  output logic [1:0] m_arburst_out,
  output logic m_arlock_out,
  output logic [2:0] m_arprot_out,
  output logic [3:0] m_arcache_out,
  output logic [3:0] m_arqos_out,
  output logic [3:0] m_arregion_out,
  // Downstream read data.
  input wire logic m_rvalid_in,
  output logic m_rready_out,
  input wire logic [ID_W-1:0] m_rid_in,
  input wire logic [DATA_W-1:0] m_rdata_in,
  input wire logic [1:0] m_rresp_in,
  input wire logic m_rlast_in,
  // Status.
  output logic decerr_seen_out,
  output logic hint_fault_out
);
  initial begin
    if (ADDR_W < 12 || ADDR_W > 32 || ID_W < 1 || DATA_W < 8) begin
      $error("brc_router: unsupported parameter values");
    end
  end

  // One transaction per direction is in flight; the owner is chosen when the address is taken.
  logic wr_busy_q;
  logic wr_dflt_q;
  logic [ID_W-1:0] wr_id_q;
  logic rd_busy_q;
  logic rd_dflt_q;
  logic [ID_W-1:0] rd_id_q;
  logic decerr_q;
  logic hint_q;

  logic aw_hit;
  logic ar_hit;
  logic aw_take;
  logic ar_take;
  logic wr_done;
  logic rd_done;
  logic dt_bvalid;
  logic [1:0] dt_bresp;
  logic dt_rvalid;
  logic dt_rlast;
  logic [1:0] dt_rresp;
  logic dt_wready;
  logic wr_pend;
  logic rd_pend;

  brc_ax_if dreq ();

  brc_default_target u_dflt (
    .clk_sys_in(clk_sys_in),
    .rst_b_in(rst_b_in),
    .req(dreq),
    .wvalid_in(s_wvalid_in && wr_busy_q && wr_dflt_q),
    .wlast_in(s_wlast_in),
    .wready_out(dt_wready),
    .bvalid_out(dt_bvalid),
    .bresp_out(dt_bresp),
    .bready_in(s_bready_in && wr_dflt_q),
    .rvalid_out(dt_rvalid),
    .rlast_out(dt_rlast),
    .rresp_out(dt_rresp),
    .rready_in(s_rready_in && rd_busy_q && rd_dflt_q)
  );

  assign aw_hit = (32'(s_awaddr_in) - MAP_BASE) < MAP_SIZE;
  assign ar_hit = (32'(s_araddr_in) - MAP_BASE) < MAP_SIZE;

  // Decode misses go to the default target; the target serves one direction at a time.
  assign wr_pend = s_awvalid_in && !wr_busy_q;
  assign rd_pend = s_arvalid_in && !rd_busy_q;
  assign dreq.valid = (wr_pend && !aw_hit) || (rd_pend && !ar_hit && !(wr_pend && !aw_hit));
  assign dreq.is_write = wr_pend && !aw_hit;
  assign dreq.len = dreq.is_write ? s_awlen_in : s_arlen_in;

  assign aw_take = wr_pend && (aw_hit ? m_awready_in : dreq.ready);
  assign ar_take = rd_pend && !(wr_pend && !aw_hit && !ar_hit) &&
                   (ar_hit ? m_arready_in : dreq.ready);
  assign s_awready_out = aw_take;
  assign s_arready_out = ar_take;

  // Non-modifiable fields pass straight through; only the bufferable bit may be cleared.
  assign m_awvalid_out = wr_pend && aw_hit;
  assign m_awaddr_out = s_awaddr_in;
  assign m_awregion_out = s_awregion_in;
  assign m_awlen_out = s_awlen_in;
  assign m_awsize_out = s_awsize_in;
  assign m_awburst_out = s_awburst_in;
  assign m_awlock_out = s_awlock_in;
  assign m_awprot_out = s_awprot_in;
  assign m_awid_out = s_awid_in;
  assign m_awqos_out = s_awqos_in;
  assign m_awcache_out = s_awcache_in &
      ~({3'h0, clear_buf_in} << BRC_CACHE_BUF_BIT);
  assign m_arvalid_out = rd_pend && ar_hit;
  assign m_araddr_out = s_araddr_in;
  assign m_arregion_out = s_arregion_in;
  assign m_arlen_out = s_arlen_in;
  assign m_arsize_out = s_arsize_in;
  assign m_arburst_out = s_arburst_in;
  assign m_arlock_out = s_arlock_in;
  assign m_arprot_out = s_arprot_in;
  assign m_arid_out = s_arid_in;
  assign m_arqos_out = s_arqos_in;
  assign m_arcache_out = s_arcache_in &
      ~({3'h0, clear_buf_in} << BRC_CACHE_BUF_BIT);

  // Write data follows the owner of the open write.
  assign m_wvalid_out = s_wvalid_in && wr_busy_q && !wr_dflt_q;
  assign m_wdata_out = s_wdata_in;
  assign m_wstrb_out = s_wstrb_in;
  assign m_wlast_out = s_wlast_in;
  assign s_wready_out = wr_busy_q && (wr_dflt_q ? dt_wready : m_wready_in);

  // Downstream codes return untouched; the default target adds decode error.
  assign s_bvalid_out = wr_busy_q && (wr_dflt_q ? dt_bvalid : m_bvalid_in);
  assign s_bresp_out = wr_dflt_q ? dt_bresp : m_bresp_in;
  assign s_bid_out = wr_dflt_q ? wr_id_q : m_bid_in;
  assign m_bready_out = wr_busy_q && !wr_dflt_q && s_bready_in;
  assign s_rvalid_out = rd_busy_q && (rd_dflt_q ? dt_rvalid : m_rvalid_in);
  assign s_rresp_out = rd_dflt_q ? dt_rresp : m_rresp_in;
  assign s_rlast_out = rd_dflt_q ? dt_rlast : m_rlast_in;
  assign s_rid_out = rd_dflt_q ? rd_id_q : m_rid_in;
  assign s_rdata_out = rd_dflt_q ? '0 : m_rdata_in;
  assign m_rready_out = rd_busy_q && !rd_dflt_q && s_rready_in;

  assign wr_done = s_bvalid_out && s_bready_in;
  assign rd_done = s_rvalid_out && s_rready_in && s_rlast_out;

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wr_busy_q <= 1'b0;
      wr_dflt_q <= 1'b0;
      wr_id_q <= '0;
    end else if (aw_take) begin
      wr_busy_q <= 1'b1;
      wr_dflt_q <= !aw_hit;
      wr_id_q <= s_awid_in;
    end else if (wr_done) begin
      wr_busy_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rd_busy_q <= 1'b0;
      rd_dflt_q <= 1'b0;
      rd_id_q <= '0;
    end else if (ar_take) begin
      rd_busy_q <= 1'b1;
      rd_dflt_q <= !ar_hit;
      rd_id_q <= s_arid_in;
    end else if (rd_done) begin
      rd_busy_q <= 1'b0;
    end
  end

  // Sticky status: a decode miss was accepted, or a master broke the hint legality.
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      decerr_q <= 1'b0;
      hint_q <= 1'b0;
    end else begin
      if ((aw_take && !aw_hit) || (ar_take && !ar_hit)) begin
        decerr_q <= 1'b1;
      end
      if ((aw_take && !s_awcache_in[BRC_CACHE_MOD_BIT] &&
           (s_awcache_in[BRC_CACHE_RA_BIT] || s_awcache_in[BRC_CACHE_WA_BIT])) ||
          (ar_take && !s_arcache_in[BRC_CACHE_MOD_BIT] &&
           (s_arcache_in[BRC_CACHE_RA_BIT] || s_arcache_in[BRC_CACHE_WA_BIT]))) begin
        hint_q <= 1'b1;
      end
    end
  end
  assign decerr_seen_out = decerr_q;
  assign hint_fault_out = hint_q;
endmodule
`default_nettype wire

// ==== brc_pkg.sv ====
// Package for the response and cache-attribute router block.
// Assumes a single bus clock domain and AXI4 style address and response channels.
package brc_pkg;
  localparam logic [1:0] BRC_RESP_OKAY = 2'h0;
  localparam logic [1:0] BRC_RESP_EXOKAY = 2'h1;
  localparam logic [1:0] BRC_RESP_SLVERR = 2'h2;
  localparam logic [1:0] BRC_RESP_DECERR = 2'h3;
  localparam int BRC_CACHE_BUF_BIT = 0;
  localparam int BRC_CACHE_MOD_BIT = 1;
  localparam int BRC_CACHE_RA_BIT = 2;
  localparam int BRC_CACHE_WA_BIT = 3;
  localparam int BRC_MAX_NM_LEN = 16;
  localparam logic [7:0] BRC_LEN_RESET = 8'h00;
  typedef enum logic [2:0] {
    BRC_IDLE = 3'b001,
    BRC_DATA = 3'b010,
    BRC_RESP = 3'b100
  } brc_state_t;
endpackage

// ==== brc_ax_if.sv ====
// Interface carrying one address channel request between the router and its default target.
// Assumes the request stands until accepted by the default target.
`timescale 1ns/1ps
`default_nettype none
interface brc_ax_if;
  logic valid;
  logic ready;
  logic is_write;
  logic [7:0] len;
  modport src (output valid, output is_write, output len, input ready);
  modport dst (input valid, input is_write, input len, output ready);
endinterface
`default_nettype wire

// ==== brc_default_target.sv ====
// Default target that answers undecodable accesses with decode error.
// Assumes write data beats arrive on the write data port, reads drain one beat a cycle.
`timescale 1ns/1ps
`default_nettype none
module brc_default_target
  import brc_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  // Request from the router.
  brc_ax_if.dst req,
  // Write data and response.
  input wire logic wvalid_in,
  input wire logic wlast_in,
  output logic wready_out,
  output logic bvalid_out,
  output logic [1:0] bresp_out,
  input wire logic bready_in,
  // Read data.
  output logic rvalid_out,
  output logic rlast_out,
  output logic [1:0] rresp_out,
  input wire logic rready_in
);
  brc_state_t state_q;
  logic wr_q;
  logic [7:0] left_q;

  assign req.ready = (state_q == BRC_IDLE);
  assign wready_out = (state_q == BRC_DATA) && wr_q;
  assign rvalid_out = (state_q == BRC_DATA) && !wr_q;
  assign rlast_out = rvalid_out && (left_q == 8'h00);
  assign bvalid_out = (state_q == BRC_RESP);
  assign bresp_out = BRC_RESP_DECERR;
  assign rresp_out = BRC_RESP_DECERR;

  // Every beat is carried out before one single response closes a write.
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_q <= BRC_IDLE;
      wr_q <= 1'b0;
      left_q <= BRC_LEN_RESET;
    end else begin
      case (state_q)
        BRC_IDLE: begin
          if (req.valid) begin
            state_q <= BRC_DATA;
            wr_q <= req.is_write;
            left_q <= req.len;
          end
        end
        BRC_DATA: begin
          if (wr_q && wvalid_in && wlast_in) begin
            state_q <= BRC_RESP;
          end else if (!wr_q && rready_in) begin
            if (left_q == 8'h00) begin
              state_q <= BRC_IDLE;
            end else begin
              left_q <= left_q - 8'h01;
            end
          end
        end
        BRC_RESP: begin
          if (bready_in) begin
            state_q <= BRC_IDLE;
          end
        end
        default: state_q <= BRC_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== brc_router_monitor.sv ====
// Checker module watching the router top-level ports.
// Assumes it is bound to brc_router and shares its single clock and reset.
`timescale 1ns/1ps
`default_nettype none
module brc_router_monitor
  import brc_pkg::*;
#(
  parameter logic [31:0] MAP_BASE = 32'h0,
  parameter logic [31:0] MAP_SIZE = 32'h10000
) (
  // Clock, reset and configuration.
  input wire logic clk_sys_in, rst_b_in, clear_buf_in,
  // Write address, both sides.
  input wire logic s_awvalid_in, s_awready_out, s_awlock_in, m_awvalid_out, m_awlock_out,
  input wire logic [31:0] s_awaddr_in, m_awaddr_out,
  input wire logic [7:0] s_awlen_in, m_awlen_out,
  input wire logic [2:0] s_awsize_in, s_awprot_in, m_awsize_out, m_awprot_out,
  input wire logic [1:0] s_awburst_in, m_awburst_out,
  input wire logic [3:0] s_awcache_in, s_awregion_in, m_awcache_out, m_awregion_out,
  // Responses, both sides.
  input wire logic s_bvalid_out, m_bvalid_in, s_rvalid_out, m_rvalid_in, s_rlast_out, m_rlast_in,
  input wire logic [1:0] s_bresp_out, m_bresp_in, s_rresp_out, m_rresp_in,
  // Status.
  input wire logic decerr_seen_out, hint_fault_out
);
  logic aw_miss;
  logic aw_take;
  assign aw_miss = (s_awaddr_in - MAP_BASE) >= MAP_SIZE;
  assign aw_take = s_awvalid_in && s_awready_out;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);
  AST_AW_FIELDS: assert property (m_awvalid_out |->
    {m_awaddr_out, m_awlen_out, m_awsize_out, m_awburst_out, m_awlock_out, m_awprot_out,
     m_awregion_out} == {s_awaddr_in, s_awlen_in, s_awsize_in, s_awburst_in, s_awlock_in,
     s_awprot_in, s_awregion_in}) else $error("forwarded write address fields differ");
  AST_AW_CACHE: assert property (m_awvalid_out |->
    m_awcache_out == (s_awcache_in & ~{3'h0, clear_buf_in})) else $error("cache field altered");
  AST_AW_NO_EXTRA: assert property (m_awvalid_out |-> s_awvalid_in)
    else $error("downstream write address without upstream request");
  AST_MISS_NOFWD: assert property (s_awvalid_in && aw_miss |-> !m_awvalid_out)
    else $error("unmapped write forwarded downstream");
  AST_MISS_FLAG: assert property (aw_take && aw_miss |=> decerr_seen_out)
    else $error("decode flag not raised");
  AST_HINT_FLAG: assert property (aw_take && !s_awcache_in[1]
    && s_awcache_in[3:2] != 2'h0 |=> hint_fault_out)
    else $error("illegal allocate hint not flagged");
  AST_B_PASS: assert property (m_bvalid_in |->
    s_bvalid_out && s_bresp_out == m_bresp_in)
    else $error("write response not passed through");
  AST_R_PASS: assert property (m_rvalid_in |->
    s_rvalid_out && s_rresp_out == m_rresp_in && s_rlast_out == m_rlast_in)
    else $error("read response not passed through");
  AST_B_DECERR: assert property (s_bvalid_out && !m_bvalid_in |->
    s_bresp_out == BRC_RESP_DECERR) else $error("internal write response not decode error");
  AST_R_DECERR: assert property (s_rvalid_out && !m_rvalid_in |->
    s_rresp_out == BRC_RESP_DECERR) else $error("internal read beat not decode error");
endmodule
`default_nettype wire

// ==== brc_slave_model.sv ====
// Downstream slave model answering the router's master port.
// Assumes one write and one read at a time; response code and write delay come from the bench.
`timescale 1ns/1ps
`default_nettype none
module brc_slave_model (
  // Clock, reset and bench controls.
  input wire logic clk_sys_in, rst_b_in,
  input wire logic [1:0] pr_resp,
  input wire logic [3:0] pr_wait,
  // Requests from the router.
  input wire logic m_awvalid_out, m_wvalid_out, m_wlast_out, m_bready_out,
  input wire logic m_arvalid_out, m_rready_out,
  input wire logic [3:0] m_awid_out, m_arid_out,
  input wire logic [7:0] m_arlen_out,
  // Answers to the router.
  output logic m_awready_in, m_wready_in, m_bvalid_in, m_arready_in, m_rvalid_in, m_rlast_in,
  output logic [3:0] m_bid_in, m_rid_in,
  output logic [1:0] m_bresp_in, m_rresp_in,
  output logic [31:0] m_rdata_in
);
  logic [1:0] ws_q;
  logic [3:0] dl_q, bid_q, rid_q;
  logic rs_q;
  logic [7:0] rn_q;
  assign m_awready_in = ws_q == 2'h0;
  assign m_wready_in = ws_q == 2'h1;
  assign m_bvalid_in = ws_q == 2'h2 && dl_q == 4'h0;
  // Idle answer lines show the inverse so stale values are never mistaken for answers.
  assign m_bresp_in = m_bvalid_in ? pr_resp : ~pr_resp;
  assign m_bid_in = m_bvalid_in ? bid_q : ~bid_q;
  assign m_arready_in = !rs_q;
  assign m_rvalid_in = rs_q;
  assign m_rlast_in = rs_q && rn_q == 8'h0;
  assign m_rresp_in = rs_q ? pr_resp : ~pr_resp;
  assign m_rid_in = rs_q ? rid_q : ~rid_q;
  assign m_rdata_in = rs_q ? {24'h0, rn_q} : ~{24'h0, rn_q};
  // One response per write burst, after the last beat.
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ws_q <= 2'h0;
      dl_q <= 4'h0;
      bid_q <= 4'h0;
    end else if (ws_q == 2'h0 && m_awvalid_out) begin
      ws_q <= 2'h1;
      bid_q <= m_awid_out;
    end else if (ws_q == 2'h1 && m_wvalid_out && m_wlast_out) begin
      ws_q <= 2'h2;
      dl_q <= pr_wait;
    end else if (ws_q == 2'h2 && dl_q != 4'h0) begin
      dl_q <= dl_q - 4'h1;
    end else if (m_bvalid_in && m_bready_out) begin
      ws_q <= 2'h0;
    end
  end
  // Every read beat is returned, error or not.
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rs_q <= 1'b0;
      rn_q <= 8'h0;
      rid_q <= 4'h0;
    end else if (!rs_q && m_arvalid_out) begin
      rs_q <= 1'b1;
      rn_q <= m_arlen_out;
      rid_q <= m_arid_out;
    end else if (rs_q && m_rready_out) begin
      rs_q <= rn_q != 8'h0;
      rn_q <= rn_q - 8'h1;
    end
  end
endmodule
`default_nettype wire

// ==== brc_router_tb.sv ====
// Self-checking bench for the router with a downstream slave model.
// Assumes the default address window of the design; the checker is bound below.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin failures++; \
  $display("[FAIL] %0t got %h expected %h", $time, a, b); end end
`define WAITF(c) n = 0; \
  do begin @(posedge clk_sys_in); n++; end while ((c) !== 1'b1 && n < 100); \
  if ((c) !== 1'b1) begin failures++; complete_run(); end
module brc_router_tb;
  import brc_pkg::*;
  logic clk_sys_in = 0, rst_b_in = 0, clear_buf_in = 0, s_awvalid_in = 0, s_awlock_in = 0;
  logic s_wvalid_in = 0, s_wlast_in = 0, s_bready_in = 0, s_arvalid_in = 0, s_arlock_in = 0;
  logic s_rready_in = 0, s_awready_out, s_wready_out, s_bvalid_out, s_arready_out, s_rvalid_out;
  logic s_rlast_out, m_awvalid_out, m_awlock_out, m_wvalid_out, m_wlast_out, m_bready_out;
  logic m_arvalid_out, m_arlock_out, m_rready_out, decerr_seen_out, hint_fault_out;
  logic m_awready_in, m_wready_in, m_bvalid_in, m_arready_in, m_rvalid_in, m_rlast_in;
  logic [31:0] s_awaddr_in = 0, s_araddr_in = 0, s_wdata_in = 0, s_rdata_out, m_awaddr_out;
  logic [31:0] m_araddr_out, m_wdata_out, m_rdata_in;
  logic [3:0] s_awid_in = 0, s_arid_in = 0, s_awcache_in = 0, s_arcache_in = 0, s_awqos_in = 0;
  logic [3:0] s_arqos_in = 0, s_awregion_in = 0, s_arregion_in = 0, s_wstrb_in = 4'hf;
  logic [3:0] pr_wait = 0, s_bid_out, s_rid_out, m_awid_out, m_arid_out, m_awcache_out;
  logic [3:0] m_arcache_out, m_awqos_out, m_arqos_out, m_awregion_out, m_arregion_out;
  logic [3:0] m_wstrb_out, m_bid_in, m_rid_in;
  logic [7:0] s_awlen_in = 0, s_arlen_in = 0, m_awlen_out, m_arlen_out;
  logic [2:0] s_awsize_in = 3'h2, s_arsize_in = 3'h2, s_awprot_in = 0, s_arprot_in = 0;
  logic [2:0] m_awsize_out, m_arsize_out, m_awprot_out, m_arprot_out;
  logic [1:0] s_awburst_in = 2'h1, s_arburst_in = 2'h1, pr_resp = 0, s_bresp_out, s_rresp_out;
  logic [1:0] m_awburst_out, m_arburst_out, m_bresp_in, m_rresp_in;
  int failures = 0;
  int checks = 0;
  brc_router DUT (.*);
  brc_slave_model u_slave (.*);
  always #25 clk_sys_in = !clk_sys_in;
  task complete_run;
    if (failures == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Write burst; f packs lock, burst, size, region, qos, prot and id; m marks an unmapped target.
  task automatic wr(input logic [31:0] a, input logic [7:0] l, input logic [3:0] c,
                    input logic [20:0] f, input logic m);
    int n, i, nb;
    s_awvalid_in <= 1'b1;
    s_awaddr_in <= a;
    s_awlen_in <= l;
    s_awcache_in <= c;
    {s_awlock_in, s_awburst_in, s_awsize_in, s_awregion_in,
     s_awqos_in, s_awprot_in, s_awid_in} <= f;
    `WAITF(s_awready_out)
    if (!m) begin
      `CHK(m_awid_out, f[3:0])
      `CHK(m_awqos_out, f[10:7])
    end
    s_awvalid_in <= 1'b0;
    for (i = 0; i <= l; i++) begin
      s_wvalid_in <= 1'b1;
      s_wlast_in <= i == l;
      s_wdata_in <= {a[15:0], 8'h5a, i[7:0]};
      `WAITF(s_wready_out)
      `CHK(m_wvalid_out, !m)
      if (!m) `CHK(m_wdata_out, s_wdata_in)
    end
    s_wvalid_in <= 1'b0;
    s_bready_in <= 1'b1;
    `WAITF(s_bvalid_out)
    `CHK(s_bresp_out, m ? BRC_RESP_DECERR : pr_resp)
    `CHK(s_bid_out, f[3:0])
    nb = 0;
    repeat (6) begin
      @(posedge clk_sys_in);
      nb += int'(s_bvalid_out === 1'b1);
    end
    `CHK(nb, 0)
    s_bready_in <= 1'b0;
  endtask
  // Read burst with every beat's response, last flag and data judged.
  task automatic rd(input logic [31:0] a, input logic [7:0] l, input logic [3:0] c,
                    input logic [20:0] f, input logic m);
    int n, i;
    logic [28:0] fa, fe;
    s_arvalid_in <= 1'b1;
    s_araddr_in <= a;
    s_arlen_in <= l;
    s_arcache_in <= c;
    {s_arlock_in, s_arburst_in, s_arsize_in, s_arregion_in,
     s_arqos_in, s_arprot_in, s_arid_in} <= f;
    `WAITF(s_arready_out)
    if (!m) begin
      fa = {m_arlen_out, m_arlock_out, m_arburst_out, m_arsize_out, m_arregion_out,
            m_arqos_out, m_arprot_out, m_arid_out};
      fe = {l, f};
      `CHK(fa, fe)
      `CHK(m_araddr_out, a)
      `CHK(m_arcache_out, c & ~{3'h0, clear_buf_in})
    end
    s_arvalid_in <= 1'b0;
    s_rready_in <= 1'b1;
    for (i = 0; i <= l; i++) begin
      `WAITF(s_rvalid_out)
      `CHK(s_rresp_out, m ? BRC_RESP_DECERR : pr_resp)
      `CHK(s_rlast_out, i == l)
      `CHK(s_rid_out, f[3:0])
      `CHK(s_rdata_out, m ? 32'h0 : {24'h0, l - i[7:0]})
    end
    s_rready_in <= 1'b0;
    @(posedge clk_sys_in);
  endtask
  // Each response code passes through, answered promptly and slowly.
  task sc_codes;
    for (int k = 0; k < 4; k++) begin
      pr_resp <= k[1:0];
      pr_wait <= 4'(k * 3);
      wr(32'h100 * k, 8'(k + 1), 4'h3, 21'(21'h0a5a5 + k), 1'b0);
      rd(32'h200 * k, 8'(k + 2), 4'h2, 21'(21'h15a53 + k), 1'b0);
    end
  endtask
  // Non-modifiable traffic with the bufferable bit cleared on the way.
  task sc_nonmod;
    clear_buf_in <= 1'b1;
    pr_resp <= BRC_RESP_EXOKAY;
    wr(32'hfffc, 8'h10, 4'h1, 21'h11c0f1, 1'b0);
    rd(32'h0040, 8'h0f, 4'h1, 21'h0a8f2, 1'b0);
    clear_buf_in <= 1'b0;
  endtask
  // Unmapped addresses get decode error after all beats, back to back.
  task sc_decode;
    `CHK(decerr_seen_out, 1'b0)
    wr(32'h0001_0000, 8'h02, 4'h0, 21'h00017, 1'b1);
    rd(32'hffff_fff0, 8'h03, 4'h0, 21'h00019, 1'b1);
    `CHK(decerr_seen_out, 1'b1)
  endtask
  // An allocate hint on a non-modifiable access is flagged.
  task sc_hint;
    `CHK(hint_fault_out, 1'b0)
    wr(32'h0080, 8'h00, 4'h8, 21'h0a002, 1'b0);
    `CHK(hint_fault_out, 1'b1)
  endtask
  initial begin
    repeat (16) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    @(posedge clk_sys_in);
    sc_codes();
    sc_nonmod();
    sc_hint();
    sc_decode();
    complete_run();
  end
endmodule
bind brc_router brc_router_monitor #(.MAP_BASE(MAP_BASE), .MAP_SIZE(MAP_SIZE)) u_mon (.*);
`default_nettype wire
